// [rtl/wsc_map.vh]
// register offsets, field positions and reset values of the wake control bank
`ifndef WSC_MAP_VH
`define WSC_MAP_VH

`define WSC_ADDR_W          7
`define WSC_OFS_BUS_CTRL    7'h04
`define WSC_OFS_INT_WAKE    7'h06
`define WSC_OFS_EXT_WAKE    7'h07
`define WSC_OFS_WDT_CTRL    7'h03

// internal wake control fields
`define WSC_IW_TMR_B        7
`define WSC_IW_TMR_A        6
`define WSC_IW_WDT_HI       2
`define WSC_IW_MASK         8'hc4
`define WSC_IW_RST          8'h00
`define WSC_IW_RESTART_KEEP 8'hc0

// external wake control fields
`define WSC_EW_INT_ALL      7
`define WSC_EW_MEAS         5
`define WSC_EW_WK3          2
`define WSC_EW_WK2          1
`define WSC_EW_WK1          0
`define WSC_EW_MASK         8'ha7
`define WSC_EW_RST          8'h07
`define WSC_EW_RESTART_KEEP 8'ha7
`define WSC_EW_FS_KEEP      8'ha0
`define WSC_EW_FS_SET       8'h07

// bus control transceiver mode field
`define WSC_BUS_MODE_W      3
`define WSC_BUS_MODE_MASK   8'h07
`define WSC_BUS_FS_KEEP     8'he0
`define WSC_BUS_MODE_WAKE   3'h1

// watchdog control, lower stop-mode deactivation bit
`define WSC_WD_LO           6
`define WSC_WD_MASK         8'hf7
`endif

// [rtl/wsc_reg8.v]
// one 8-bit masked register with reset, restart, write and hardware load
`timescale 1ns/100ps
module wsc_reg8 #(
	parameter [7:0] RST_VAL   = 8'h00,
	parameter [7:0] WR_MASK   = 8'hff,
	parameter [7:0] KEEP_MASK = 8'h00
) (
	// clock and resets
	input  wire       clk_sys_i,
	input  wire       rstn_i,
	input  wire       soft_rst_i,
	input  wire       restart_i,
	// host write
	input  wire       wr_i,
	input  wire [7:0] wdata_i,
	// hardware load, wins over a host write
	input  wire       hw_ld_i,
	input  wire [7:0] hw_mask_i,
	input  wire [7:0] hw_data_i,
	// value
	output reg  [7:0] q_o
);
	reg [7:0] d;

	always @* begin
		d = q_o;
		if (wr_i)
			d = (q_o & ~WR_MASK) | (wdata_i & WR_MASK);
		if (hw_ld_i)
			d = (d & ~hw_mask_i) | (hw_data_i & hw_mask_i);
	end

	always @(posedge clk_sys_i) begin
		if (!rstn_i || soft_rst_i)
			q_o <= RST_VAL;
		else if (restart_i)
			q_o <= q_o & KEEP_MASK;
		else
			q_o <= d & WR_MASK;
	end
endmodule // wsc_reg8

// [rtl/wsc_wake_gate.v]
// wake source qualification and interrupt source selection
`timescale 1ns/100ps
module wsc_wake_gate (
	// configuration
	input  wire [7:0] int_wake_i,
	input  wire [7:0] ext_wake_i,
	input  wire [2:0] bus_mode_i,
	// events
	input  wire       tmr_a_evt_i,
	input  wire       tmr_b_evt_i,
	input  wire [2:0] wk_evt_i,
	input  wire       bus_evt_i,
	input  wire       other_status_i,
	// results
	output wire       wake_o,
	output wire       irq_o,
	output wire       measure_o
);
	wire meas = ext_wake_i[5];
	wire wk1  = wk_evt_i[0] & ext_wake_i[0] & ~meas;
	wire wk2  = wk_evt_i[1] & ext_wake_i[1] & ~meas;
	wire wk3  = wk_evt_i[2] & ext_wake_i[2];
	wire tb   = tmr_b_evt_i & int_wake_i[7];
	wire ta   = tmr_a_evt_i & int_wake_i[6];
	// both wake capable codes, with and without selective wake
	wire bw   = bus_evt_i & (bus_mode_i[1:0] == 2'h1);

	assign wake_o    = wk1 | wk2 | wk3 | ta | tb | bw;
	assign irq_o     = wake_o | (ext_wake_i[7] & other_status_i);
	assign measure_o = meas;
endmodule // wsc_wake_gate

// [rtl/wsc_wake_ctrl.v]
// wake source control register bank with fail-safe forcing
`timescale 1ns/100ps
`include "wsc_map.vh"
module wsc_wake_ctrl (
	// clock and resets
	input  wire       clk_sys_i,
	input  wire       rstn_i,
	input  wire       soft_rst_i,
	input  wire       restart_i,
	// register access from the serial control interface
	input  wire       wr_i,
	input  wire       rd_i,
	input  wire [6:0] addr_i,
	input  wire [7:0] wdata_i,
	output reg  [7:0] rdata_o,
	// device state
	input  wire       fail_safe_i,
	input  wire       normal_mode_i,
	input  wire       stop_mode_i,
	input  wire       wdt_code_ld_i,
	input  wire [1:0] wdt_code_i,
	// wake events
	input  wire       tmr_a_evt_i,
	input  wire       tmr_b_evt_i,
	input  wire [2:0] wk_evt_i,
	input  wire       bus_evt_i,
	input  wire       other_status_i,
	// results
	output reg        wake_o,
	output reg        irq_o,
	output reg        measure_en_o,
	output reg        wdt_stop_off_o,
	output reg  [2:0] bus_mode_o
);
	// ------------------------------------------------------------
	// register selects and fail-safe entry edge
	// ------------------------------------------------------------
	reg        fs_q;
	wire       fs_entry = fail_safe_i & ~fs_q;
	wire       wr_iw    = wr_i & (addr_i == `WSC_OFS_INT_WAKE);
	wire       wr_ew    = wr_i & (addr_i == `WSC_OFS_EXT_WAKE);
	wire       wr_bus   = wr_i & (addr_i == `WSC_OFS_BUS_CTRL);
	wire       wr_wd    = wr_i & (addr_i == `WSC_OFS_WDT_CTRL);
	wire [7:0] iw_q;
	wire [7:0] ew_q;
	wire [7:0] bus_q;
	wire [7:0] wd_q;
	wire       wake_c;
	wire       irq_c;
	wire       meas_c;

	always @(posedge clk_sys_i) begin
		if (!rstn_i)
			fs_q <= 1'b0;
		else
			fs_q <= fail_safe_i;
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	// internal wake control; code bit loaded by the watchdog logic
	wsc_reg8 #(
		.RST_VAL   (`WSC_IW_RST),
		.WR_MASK   (`WSC_IW_MASK),
		.KEEP_MASK (`WSC_IW_RESTART_KEEP)
	) u_iw (
		.clk_sys_i  (clk_sys_i),
		.rstn_i     (rstn_i),
		.soft_rst_i (soft_rst_i),
		.restart_i  (restart_i),
		.wr_i       (wr_iw),
		.wdata_i    (wdata_i),
		.hw_ld_i    (wdt_code_ld_i),
		.hw_mask_i  (8'h04),
		.hw_data_i  ({5'h00, wdt_code_i[1], 2'h0}),
		.q_o        (iw_q)
	);

	// external wake control; fail-safe sets all three wake input enables but keeps the measure bit, which still blocks WK1 and WK2
	wsc_reg8 #(
		.RST_VAL   (`WSC_EW_RST),
		.WR_MASK   (`WSC_EW_MASK),
		.KEEP_MASK (`WSC_EW_RESTART_KEEP)
	) u_ew (
		.clk_sys_i  (clk_sys_i),
		.rstn_i     (rstn_i),
		.soft_rst_i (soft_rst_i),
		.restart_i  (restart_i),
		.wr_i       (wr_ew),
		.wdata_i    (wdata_i),
		.hw_ld_i    (fs_entry),
		.hw_mask_i  (~`WSC_EW_FS_KEEP),
		.hw_data_i  (`WSC_EW_FS_SET),
		.q_o        (ew_q)
	);

	// bus control mode field; fail-safe forces wake capable
	wsc_reg8 #(
		.RST_VAL   (8'h00),
		.WR_MASK   (`WSC_BUS_MODE_MASK),
		.KEEP_MASK (8'h03)
	) u_bus (
		.clk_sys_i  (clk_sys_i),
		.rstn_i     (rstn_i),
		.soft_rst_i (soft_rst_i),
		.restart_i  (restart_i),
		.wr_i       (wr_bus),
		.wdata_i    (wdata_i),
		.hw_ld_i    (fs_entry),
		.hw_mask_i  (~`WSC_BUS_FS_KEEP),
		.hw_data_i  ({5'h00, `WSC_BUS_MODE_WAKE}),
		.q_o        (bus_q)
	);

	// watchdog control, lower code bit loaded by the watchdog logic
	wsc_reg8 #(
		.RST_VAL   (8'h00),
		.WR_MASK   (`WSC_WD_MASK),
		.KEEP_MASK (8'h00)
	) u_wd (
		.clk_sys_i  (clk_sys_i),
		.rstn_i     (rstn_i),
		.soft_rst_i (soft_rst_i),
		.restart_i  (restart_i),
		.wr_i       (wr_wd),
		.wdata_i    (wdata_i),
		.hw_ld_i    (wdt_code_ld_i),
		.hw_mask_i  (8'h40),
		.hw_data_i  ({1'b0, wdt_code_i[0], 6'h00}),
		.q_o        (wd_q)
	);

	// ------------------------------------------------------------
	// wake qualification
	// ------------------------------------------------------------
	wsc_wake_gate u_gate (
		.int_wake_i     (iw_q),
		.ext_wake_i     (ew_q),
		.bus_mode_i     (bus_q[2:0]),
		.tmr_a_evt_i    (tmr_a_evt_i),
		.tmr_b_evt_i    (tmr_b_evt_i),
		.wk_evt_i       (wk_evt_i),
		.bus_evt_i      (bus_evt_i),
		.other_status_i (other_status_i),
		.wake_o         (wake_c),
		.irq_o          (irq_c),
		.measure_o      (meas_c)
	);

	// ------------------------------------------------------------
	// registered outputs and read data
	// ------------------------------------------------------------
	// read data holds when idle so the host may sample late
	always @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			rdata_o        <= 8'h00;
			wake_o         <= 1'b0;
			irq_o          <= 1'b0;
			measure_en_o   <= 1'b0;
			wdt_stop_off_o <= 1'b0;
			bus_mode_o     <= 3'h0;
		end else begin
			wake_o         <= wake_c;
			irq_o          <= irq_c;
			measure_en_o   <= meas_c & normal_mode_i;
			// code 00 keeps the watchdog running in stop mode
			wdt_stop_off_o <= stop_mode_i &
				(iw_q[`WSC_IW_WDT_HI] | wd_q[`WSC_WD_LO]);
			bus_mode_o     <= bus_q[2:0];
			if (rd_i) begin
				case (addr_i)
				`WSC_OFS_INT_WAKE: rdata_o <= iw_q & `WSC_IW_MASK;
				`WSC_OFS_EXT_WAKE: rdata_o <= ew_q & `WSC_EW_MASK;
				`WSC_OFS_BUS_CTRL: rdata_o <= bus_q;
				`WSC_OFS_WDT_CTRL: rdata_o <= wd_q;
				default:           rdata_o <= 8'h00;
				endcase
			end
		end
	end
endmodule // wsc_wake_ctrl

// [test/wsc_host_model.sv]
// host model driving the register access strobes
`timescale 1ns/100ps
module wsc_host_model (
	// clock
	input  wire       clk_sys_i,
	// register access
	output reg        wr_o = 1'b0,
	output reg        rd_o = 1'b0,
	output reg  [6:0] addr_o = 7'h00,
	output reg  [7:0] wdata_o = 8'h00
);
	// one access a cycle; idle data inverted so a stale byte looks wrong
	// level status of wake inputs is never read back
	task xfer(input w, input r, input [6:0] a, input [7:0] d);
		@(negedge clk_sys_i);
		wr_o = w;
		rd_o = r;
		addr_o = a;
		wdata_o = w ? d : ~wdata_o;
	endtask
endmodule // wsc_host_model

// [test/wsc_wake_ctrl_sva.sv]
// assertion checker on the wake control bank ports
`timescale 1ns/100ps
module wsc_wake_ctrl_sva (
	// clock, resets and reads
	input wire       clk_sys_i,
	input wire       rstn_i,
	input wire       soft_rst_i,
	input wire       restart_i,
	input wire       rd_i,
	input wire [6:0] addr_i,
	input wire [7:0] rdata_o,
	// state and events
	input wire       fail_safe_i,
	input wire       normal_mode_i,
	input wire       stop_mode_i,
	input wire       tmr_a_evt_i,
	input wire       tmr_b_evt_i,
	input wire [2:0] wk_evt_i,
	input wire       bus_evt_i,
	input wire       other_status_i,
	// results
	input wire       wake_o,
	input wire       irq_o,
	input wire       measure_en_o,
	input wire       wdt_stop_off_o,
	input wire [2:0] bus_mode_o
);
	// ------
	// port relations
	// ------
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rstn_i);
	sequence s_quiet;
		!tmr_a_evt_i && !tmr_b_evt_i && wk_evt_i == 3'h0 && !bus_evt_i;
	endsequence
	// resets own the bank on their edge, so only a clean entry is judged
	sequence s_fs_entry;
		$rose(fail_safe_i) && !soft_rst_i && !restart_i;
	endsequence
	a_int_resv: assert property (rd_i && addr_i == 7'h06 |=>
		(rdata_o & 8'h3b) == 8'h00) else $error("internal reserved set");
	a_ext_resv: assert property (rd_i && addr_i == 7'h07 |=>
		(rdata_o & 8'h58) == 8'h00) else $error("external reserved set");
	a_quiet_wake: assert property (s_quiet |=> !wake_o)
		else $error("wake without event");
	a_quiet_irq: assert property (s_quiet ##0 !other_status_i |=>
		!irq_o) else $error("irq without cause");
	a_wake_irq: assert property (wake_o |-> irq_o)
		else $error("wake did not raise irq");
	a_meas_mode: assert property (!normal_mode_i |=> !measure_en_o)
		else $error("measure outside normal mode");
	a_wdt_stop: assert property (!stop_mode_i |=> !wdt_stop_off_o)
		else $error("watchdog off outside stop");
	a_fs_bus: assert property (s_fs_entry |-> ##[1:2]
		bus_mode_o == 3'h1) else $error("bus mode not forced");
endmodule // wsc_wake_ctrl_sva

bind wsc_wake_ctrl wsc_wake_ctrl_sva u_sva (.*);

// [test/wsc_wake_ctrl_tb_top.sv]
// self-checking bench of the wake control bank
`timescale 1ns/100ps
module wsc_wake_ctrl_tb_top;
	reg        clk_sys_i = 1'b0, rstn_i = 1'b0;
	reg        soft_rst_i = 1'b0, restart_i = 1'b0, fail_safe_i = 1'b0;
	reg        normal_mode_i = 1'b0, stop_mode_i = 1'b0;
	reg        wdt_code_ld_i = 1'b0, other_status_i = 1'b0;
	reg  [1:0] wdt_code_i = 2'h0;
	reg        tmr_a_evt_i = 1'b0, tmr_b_evt_i = 1'b0, bus_evt_i = 1'b0;
	reg  [2:0] wk_evt_i = 3'h0;
	wire       wr_i, rd_i, wake_o, irq_o, measure_en_o, wdt_stop_off_o;
	wire [6:0] addr_i;
	wire [7:0] wdata_i, rdata_o;
	wire [2:0] bus_mode_o;
	reg  [7:0] iw = 8'h00, ew = 8'h07, bs = 8'h00, q[$];
	reg  [6:0] a;
	reg        wd6 = 1'b0, rd_seen = 1'b0;
	reg [31:0] rnd, seed = 32'h71e62ef6;
	integer    err_total = 0, cmp_count = 0, cyc = 0;
	always #25 clk_sys_i = ~clk_sys_i;
	wsc_host_model u_host (.clk_sys_i(clk_sys_i), .wr_o(wr_i),
		.rd_o(rd_i), .addr_o(addr_i), .wdata_o(wdata_i));
	wsc_wake_ctrl dut (.*);
	task cmp(input string nm, input [7:0] e, input [7:0] g);
		cmp_count = cmp_count + 1;
		if (g !== e) begin
			err_total = err_total + 1;
			$display("wrong value %s exp %h got %h", nm, e, g);
		end
	endtask
	task stop_test;
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task idle;
		u_host.xfer(1'b0, 1'b0, 7'h00, 8'h00);
	endtask
	task rd(input [6:0] ad, input [7:0] e);
		u_host.xfer(1'b0, 1'b1, ad, 8'h00);
		q.push_back(e);
	endtask
	// shadow keeps only writable bits
	task wr(input [6:0] ad, input [7:0] d);
		u_host.xfer(1'b1, 1'b0, ad, d);
		if (ad == 7'h06) iw = d & 8'hc4;
		if (ad == 7'h07) ew = d & 8'ha7;
		if (ad == 7'h04) bs = d & 8'h07;
		if (ad == 7'h03) wd6 = d[6];
	endtask
	task ev_chk(input [5:0] e);
		reg f;
		idle;
		{bus_evt_i, tmr_b_evt_i, tmr_a_evt_i, wk_evt_i} = e;
		rnd = $random(seed);
		{other_status_i, normal_mode_i, stop_mode_i} = rnd[2:0];
		f = |(e & {bs[1:0] == 2'b01, iw[7:6], ew[2], ew[1:0] & ~{2{ew[5]}}});
		idle;
		cmp("wake", f, wake_o);
		cmp("irq", f | (ew[7] & other_status_i), irq_o);
		cmp("measure", ew[5] & normal_mode_i, measure_en_o);
		cmp("wdt off", stop_mode_i & (iw[2] | wd6), wdt_stop_off_o);
		cmp("bus mode", bs & 8'h07, {5'h00, bus_mode_o});
		{bus_evt_i, tmr_b_evt_i, tmr_a_evt_i, wk_evt_i} = 6'h00;
	endtask
	always @(posedge clk_sys_i) rd_seen <= rd_i;
	always @(negedge clk_sys_i)
		if (rd_seen) cmp("rdata", q.pop_front(), rdata_o);
	// hang guard, far above the roughly 160 cycles needed
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			err_total = err_total + 1;
			stop_test;
		end
	end
	initial begin
		repeat (8) @(negedge clk_sys_i);
		rstn_i = 1'b1;
		rd(7'h06, 8'h00);
		rd(7'h07, 8'h07);
		$display("test reset values done");
		repeat (24) begin
			rnd = $random(seed);
			a = 7'h04 + rnd[9:8];
			wr(7'h03, rnd[23:16]);
			wr(a, rnd[7:0]);
			rd(a, ex(a));
			ev_chk(rnd[15:10]);
		end
		$display("test random access done");
		wr(7'h06, 8'hff);
		wr(7'h07, 8'hff);
		wr(7'h04, 8'h06);
		idle;
		restart_i = 1'b1;
		idle;
		restart_i = 1'b0;
		{iw, ew, bs, wd6} = {iw & 8'hc0, ew & 8'ha7, bs & 8'h03, 1'b0};
		rd(7'h06, iw);
		rd(7'h07, ew);
		ev_chk(6'h3f);
		$display("test restart done");
		wr(7'h07, 8'h20);
		u_host.xfer(1'b1, 1'b0, 7'h04, 8'h03);
		fail_safe_i = 1'b1;
		idle;
		{ew, bs} = 16'h2701;
		rd(7'h07, ew);
		rd(7'h04, bs);
		fail_safe_i = 1'b0;
		$display("test fail-safe done");
		u_host.xfer(1'b1, 1'b0, 7'h06, 8'h00);
		wdt_code_ld_i = 1'b1;
		wdt_code_i = 2'h2;
		idle;
		wdt_code_ld_i = 1'b0;
		{iw, wd6} = 9'h008;
		rd(7'h06, iw);
		repeat (4) ev_chk(6'h00);
		$display("test stop code done");
		soft_rst_i = 1'b1;
		idle;
		soft_rst_i = 1'b0;
		{iw, ew, bs, wd6} = 25'h000e00;
		rd(7'h06, iw);
		rd(7'h07, ew);
		idle;
		idle;
		$display("test soft reset done");
		stop_test;
	end
	function [7:0] ex(input [6:0] ad);
		ex = ad == 7'h06 ? iw : ad == 7'h07 ? ew : ad == 7'h04 ? bs : 8'h00;
	endfunction
endmodule // wsc_wake_ctrl_tb_top
